// ---- exc_defines.svh ----
`ifndef EXC_DEFINES_SVH
`define EXC_DEFINES_SVH

// Register byte offsets on the Wishbone slave
`define OFS_STATUS 6'h00
`define OFS_RESTART 6'h04
`define OFS_FAULT_INFO 6'h08
`define OFS_EVENTS 6'h0C
`define OFS_EVMASK 6'h10
`define OFS_CTRL 6'h14
// Status register fields
`define ST_IE 0
`define ST_EXL 1
`define ST_ERL 2
`define ST_KSU_LO 3
`define ST_IM_LO 8
// Base mode encodings
`define MODE_KERNEL 2'h0
`define MODE_SUPER 2'h1
`define MODE_USER 2'h2
// Reset values
`define STATUS_RESET 32'h00000004
`define HANDLER_ADDR_DEFAULT 64'hFFFFFFFF80000180
// Event status bits
`define EV_TAKEN 0
`define EV_PARITY 1
`define EV_RETURN 2

`endif

// ---- exc_pkg.sv ----
package exc_pkg;
	// Exception codes, lowest wins inside one stage
	typedef enum logic [3:0] {
		EXC_NONE = 4'h0,
		EXC_TLB_REFILL = 4'h1,
		EXC_TLB_INVALID = 4'h2,
		EXC_TLB_MODIFY = 4'h3,
		EXC_OVERFLOW = 4'h4,
		EXC_SYSCALL = 4'h5,
		EXC_PARITY = 4'h6,
		EXC_INTERRUPT = 4'h7
	} exc_code_type;

	// One pipeline stage's report
	typedef struct packed {
		logic valid;
		logic in_delay_slot;
		logic [63:0] pc;
		logic [63:0] vaddr;
		logic tlb_access;
		logic tlb_store;
		logic tlb_hit;
		logic tlb_entry_valid;
		logic tlb_entry_dirty;
		logic overflow;
		logic syscall;
		logic parity_load_hit;
	} stage_report_type;

	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_ENTER = 3'b010,
		ST_HOLD = 3'b100
	} ctl_state_type;
endpackage

// ---- cpu_exception_control.sv ----
// The register offsets and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "exc_defines.svh"

// Notes on behaviour
// - Accepts translation, overflow, interrupt and system call exception sources.
// - On exception, stop normal sequencing and enter kernel mode.
// - After exception, mask interrupts and fetch from fixed handler address.
// - Restart register gets faulting address, or branch address for delay slot.
// - Hold interrupt enable, base mode, exception level and error level.
// - Interrupt allowed only with enable 1, both levels 0, mask bit 1.
// - Effective mode is base mode when levels 0, else kernel.
// - Return from handler clears exception level, restoring base mode.
// - Abort faulting instruction and all younger ones for re-execution.
// - Exceptions of aborted younger instructions are discarded.
// - Pending exceptions are taken in fetch order, oldest first.
// - Parity fault on load hit does not block register write-back.
// - Parity fault updates restart and fault info with load's address.
// - No matching translation entry raises refill exception.
// - Matched entry denying access raises modify or invalid exception.
// - Entry valid flag decides validity only, never the match itself.
module cpu_exception_control #(
	parameter int STAGES = 3,
	parameter logic [63:0] HANDLER_ADDR = `HANDLER_ADDR_DEFAULT
) (
	input wire logic clock,
	input wire logic rst,
	// Stage reports, index 0 is the oldest instruction
	input wire exc_pkg::stage_report_type [STAGES-1:0] report,
	input wire logic [7:0] irq_pending,
	input wire logic return_from_handler,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [5:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic [STAGES-1:0] flush,
	output logic redirect,
	output logic [63:0] redirect_pc,
	output logic kernel_mode,
	output logic wb_allow,
	output logic [3:0] exc_code,
	output logic irq_o
);
	logic [63:0] restart_pc_reg;
	logic [63:0] parity_fault_info_reg;
	logic global_irq_enable;
	logic exception_level_bit;
	logic error_level_bit;
	logic [1:0] base_mode;
	logic [7:0] irq_mask_field;
	logic [2:0] ev_status;
	logic [2:0] ev_mask;
	logic [63:0] prev_pc;
	exc_pkg::ctl_state_type state;
	localparam logic [31:0] STATUS_INIT = `STATUS_RESET;

	// Exception check of one stage: translation, overflow, system call, parity
	function automatic exc_pkg::exc_code_type classify(input exc_pkg::stage_report_type r);
		exc_pkg::exc_code_type c;
		c = exc_pkg::EXC_NONE;
		if (r.tlb_access && !r.tlb_hit) begin
			c = exc_pkg::EXC_TLB_REFILL;
		end else if (r.tlb_access && !r.tlb_entry_valid) begin
			c = exc_pkg::EXC_TLB_INVALID;
		end else if (r.tlb_access && r.tlb_store && !r.tlb_entry_dirty) begin
			c = exc_pkg::EXC_TLB_MODIFY;
		end else if (r.overflow) begin
			c = exc_pkg::EXC_OVERFLOW;
		end else if (r.syscall) begin
			c = exc_pkg::EXC_SYSCALL;
		end else if (r.parity_load_hit) begin
			c = exc_pkg::EXC_PARITY;
		end
		return c;
	endfunction

	// Interrupt lines come from pins, so two flops before any logic reads them
	logic [7:0] irq_meta;
	logic [7:0] irq_sync;
	always_ff @(posedge clock) begin
		if (rst) begin
			irq_meta <= 8'h00;
			irq_sync <= 8'h00;
		end else begin
			irq_meta <= irq_pending;
			irq_sync <= irq_meta;
		end
	end

	// Interrupt gate
	logic irq_ok;
	assign irq_ok = global_irq_enable && !exception_level_bit && !error_level_bit
		&& |(irq_mask_field & irq_sync);

	// Pending interrupt wins, else oldest faulting stage; younger reports ignored
	logic found;
	logic [$clog2(STAGES+1)-1:0] sel_idx;
	exc_pkg::exc_code_type sel_code;
	always_comb begin
		found = 1'b0;
		sel_idx = '0;
		sel_code = exc_pkg::EXC_NONE;
		if (irq_ok) begin
			found = 1'b1;
			sel_code = exc_pkg::EXC_INTERRUPT;
		end
		for (int i = 0; i < STAGES; i++) begin
			if (!found && report[i].valid && classify(report[i]) != exc_pkg::EXC_NONE) begin
				found = 1'b1;
				sel_idx = i[$clog2(STAGES+1)-1:0];
				sel_code = classify(report[i]);
			end
		end
	end

	logic take;
	assign take = found && state == exc_pkg::ST_RUN;
	exc_pkg::stage_report_type sel_rep;
	assign sel_rep = report[sel_idx];

	// Control state: one entry, then wait two cycles (ST_ENTER, ST_HOLD)
	always_ff @(posedge clock) begin
		if (rst) begin
			state <= exc_pkg::ST_RUN;
		end else begin
			unique case (state)
				exc_pkg::ST_RUN: begin
					if (take) begin
						state <= exc_pkg::ST_ENTER;
					end
				end
				exc_pkg::ST_ENTER: begin
					state <= exc_pkg::ST_HOLD;
				end
				exc_pkg::ST_HOLD: begin
					state <= exc_pkg::ST_RUN;
				end
			endcase
		end
	end

	// Branch address of the previous instruction for delay slots
	always_ff @(posedge clock) begin
		if (rst) begin
			prev_pc <= 64'h0;
		end else if (report[0].valid) begin
			prev_pc <= report[0].pc;
		end
	end

	// Kill faulting stage and younger
	always_ff @(posedge clock) begin
		if (rst) begin
			flush <= '0;
			redirect <= 1'b0;
			redirect_pc <= 64'h0;
			exc_code <= 4'h0;
		end else begin
			redirect <= take;
			redirect_pc <= HANDLER_ADDR;
			for (int i = 0; i < STAGES; i++) begin
				flush[i] <= take && (sel_code == exc_pkg::EXC_INTERRUPT || i >= sel_idx);
			end
			if (take) begin
				exc_code <= sel_code;
			end
		end
	end

	// Write-back of a parity load hit still proceeds
	always_ff @(posedge clock) begin
		if (rst) begin
			wb_allow <= 1'b0;
		end else begin
			wb_allow <= report[0].valid && (classify(report[0]) == exc_pkg::EXC_NONE
				|| classify(report[0]) == exc_pkg::EXC_PARITY);
		end
	end

	// Restart address; interrupts restart at the oldest instruction
	logic [63:0] restart_addr;
	always_comb begin
		if (sel_rep.in_delay_slot) begin
			restart_addr = sel_idx == '0 ? prev_pc : report[sel_idx - 1'b1].pc;
		end else begin
			restart_addr = sel_rep.pc;
		end
	end

	logic wr;
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i == 4'hF;

	// Mode and level bits
	always_ff @(posedge clock) begin
		if (rst) begin
			global_irq_enable <= STATUS_INIT[`ST_IE];
			exception_level_bit <= STATUS_INIT[`ST_EXL];
			error_level_bit <= STATUS_INIT[`ST_ERL];
			base_mode <= STATUS_INIT[`ST_KSU_LO +: 2];
			irq_mask_field <= STATUS_INIT[`ST_IM_LO +: 8];
			restart_pc_reg <= 64'h0;
		end else begin
			if (wr && wb_adr_i == `OFS_STATUS) begin
				global_irq_enable <= wb_dat_i[`ST_IE];
				exception_level_bit <= wb_dat_i[`ST_EXL];
				error_level_bit <= wb_dat_i[`ST_ERL];
				base_mode <= wb_dat_i[`ST_KSU_LO +: 2];
				irq_mask_field <= wb_dat_i[`ST_IM_LO +: 8];
			end
			if (return_from_handler) begin
				exception_level_bit <= 1'b0;
			end
			if (take) begin
				exception_level_bit <= 1'b1;
				restart_pc_reg <= restart_addr;
			end
		end
	end

	// Fault info for parity errors
	always_ff @(posedge clock) begin
		if (rst) begin
			parity_fault_info_reg <= 64'h0;
		end else if (take && sel_code == exc_pkg::EXC_PARITY) begin
			parity_fault_info_reg <= sel_rep.vaddr;
		end
	end

	// Effective mode
	always_ff @(posedge clock) begin
		if (rst) begin
			kernel_mode <= 1'b1;
		end else begin
			kernel_mode <= take || exception_level_bit || error_level_bit
				|| base_mode == `MODE_KERNEL;
		end
	end

	// Sticky events; a set in the same cycle beats a clear
	logic [2:0] ev_set;
	assign ev_set = {return_from_handler, take && sel_code == exc_pkg::EXC_PARITY, take};
	always_ff @(posedge clock) begin
		if (rst) begin
			ev_status <= 3'h0;
			ev_mask <= 3'h0;
			irq_o <= 1'b0;
		end else begin
			ev_status <= (ev_status & ~((wr && wb_adr_i == `OFS_EVENTS) ? wb_dat_i[2:0] : 3'h0)) | ev_set;
			if (wr && wb_adr_i == `OFS_EVMASK) begin
				ev_mask <= wb_dat_i[2:0];
			end
			irq_o <= |(ev_status & ev_mask);
		end
	end

	// Bus reads, ack one cycle after the strobe
	always_ff @(posedge clock) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			unique case (wb_adr_i)
				`OFS_STATUS: wb_dat_o <= {16'h0, irq_mask_field, 3'h0, base_mode,
					error_level_bit, exception_level_bit, global_irq_enable};
				`OFS_RESTART: wb_dat_o <= restart_pc_reg[31:0];
				`OFS_FAULT_INFO: wb_dat_o <= parity_fault_info_reg[31:0];
				`OFS_EVENTS: wb_dat_o <= {29'h0, ev_status};
				`OFS_EVMASK: wb_dat_o <= {29'h0, ev_mask};
				`OFS_CTRL: wb_dat_o <= {24'h0, 4'h0, exc_code};
				default: wb_dat_o <= 32'h0;
			endcase
		end
	end

	a_entry_sets_level: assert property (@(posedge clock) disable iff (rst)
		take |=> exception_level_bit && redirect) else $error("entry did not set level");
	a_irq_gate: assert property (@(posedge clock) disable iff (rst)
		(take && sel_code == exc_pkg::EXC_INTERRUPT) |-> global_irq_enable && !exception_level_bit)
		else $error("interrupt taken while masked");
	a_kernel_forced: assert property (@(posedge clock) disable iff (rst)
		(exception_level_bit || error_level_bit) |=> kernel_mode) else $error("not kernel");
	a_return_clears: assert property (@(posedge clock) disable iff (rst)
		(return_from_handler && !take) |=> !exception_level_bit) else $error("level not cleared");
	a_handler_fetch: assert property (@(posedge clock) disable iff (rst)
		take |=> redirect_pc == HANDLER_ADDR) else $error("wrong handler");
	a_restart_addr: assert property (@(posedge clock) disable iff (rst)
		(take && !sel_rep.in_delay_slot) |=> restart_pc_reg == $past(sel_rep.pc)) else $error("bad restart");
	a_flush_younger: assert property (@(posedge clock) disable iff (rst)
		take |=> flush[STAGES-1]) else $error("younger not flushed");
	a_refill_miss: assert property (@(posedge clock) disable iff (rst)
		(report[0].valid && report[0].tlb_access && !report[0].tlb_hit && state == exc_pkg::ST_RUN && !irq_ok)
		|=> exc_code == exc_pkg::EXC_TLB_REFILL) else $error("no refill");
	a_parity_info: assert property (@(posedge clock) disable iff (rst)
		(take && sel_code == exc_pkg::EXC_PARITY) |=> parity_fault_info_reg == $past(sel_rep.vaddr))
		else $error("fault info missing");
	a_bus_ack: assert property (@(posedge clock) disable iff (rst)
		wb_ack_o |=> !wb_ack_o) else $error("ack held");
	a_kernel_base: assert property (@(posedge clock) disable iff (rst)
		(!take && !exception_level_bit && !error_level_bit && base_mode != `MODE_KERNEL) |=> !kernel_mode)
		else $error("base mode not followed");
	a_invalid_hit: assert property (@(posedge clock) disable iff (rst)
		(report[0].valid && report[0].tlb_access && report[0].tlb_hit && !report[0].tlb_entry_valid
		&& state == exc_pkg::ST_RUN && !irq_ok) |=> exc_code == exc_pkg::EXC_TLB_INVALID)
		else $error("no invalid exception");
	a_modify_store: assert property (@(posedge clock) disable iff (rst)
		(report[0].valid && report[0].tlb_access && report[0].tlb_hit && report[0].tlb_entry_valid
		&& report[0].tlb_store && !report[0].tlb_entry_dirty && state == exc_pkg::ST_RUN && !irq_ok)
		|=> exc_code == exc_pkg::EXC_TLB_MODIFY) else $error("no modify exception");
	a_parity_wb: assert property (@(posedge clock) disable iff (rst)
		(report[0].valid && report[0].parity_load_hit && !report[0].tlb_access && !report[0].overflow
		&& !report[0].syscall) |=> wb_allow) else $error("parity load write-back blocked");
	a_single_entry: assert property (@(posedge clock) disable iff (rst)
		redirect |=> !redirect) else $error("redirect held");
	a_fetch_order: assert property (@(posedge clock) disable iff (rst)
		(take && sel_code != exc_pkg::EXC_INTERRUPT && sel_idx != '0)
		|-> !(report[0].valid && classify(report[0]) != exc_pkg::EXC_NONE))
		else $error("younger fault taken first");
endmodule
`default_nettype wire

// ---- pipe_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pipe_model #(
	parameter int STAGES = 3
) (
	input wire logic clock,
	input wire logic load,
	input wire exc_pkg::stage_report_type [STAGES-1:0] next_report,
	input wire logic [STAGES-1:0] flush,
	output var exc_pkg::stage_report_type [STAGES-1:0] report
);
	// Killed slots vanish whole, so a stale fault cannot be taken later
	always_ff @(posedge clock) begin
		for (int i = 0; i < STAGES; i++) begin
			if (load)
				report[i] <= next_report[i];
			else if (flush[i])
				report[i] <= '0;
		end
	end
endmodule
`default_nettype wire

// ---- tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "exc_defines.svh"
module tb;
	logic clock = 1'b0;
	logic rst, load, return_from_handler, wb_cyc_i, wb_stb_i, wb_we_i, redirect, kernel_mode, wb_allow, irq_o;
	logic wb_ack_o;
	logic [7:0] irq_pending;
	logic [5:0] wb_adr_i;
	logic [3:0] wb_sel_i, exc_code;
	logic [31:0] wb_dat_i, wb_dat_o, q;
	logic [2:0] flush;
	logic [63:0] redirect_pc, pc;
	exc_pkg::stage_report_type [2:0] next_report, report;
	int err_count = 0;
	int n_checks = 0;
	int b;
	always #10 clock = ~clock;
	pipe_model PM (.clock(clock), .load(load), .next_report(next_report), .flush(flush), .report(report));
	cpu_exception_control DUT (.clock(clock), .rst(rst), .report(report), .irq_pending(irq_pending),
		.return_from_handler(return_from_handler), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.flush(flush), .redirect(redirect), .redirect_pc(redirect_pc), .kernel_mode(kernel_mode),
		.wb_allow(wb_allow), .exc_code(exc_code), .irq_o(irq_o));
	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	function automatic logic [63:0] rnd();
		return {$urandom(), $urandom()} & ~64'h3;
	endfunction
	function automatic logic [3:0] tlb_exp(input logic hit, input logic ok, input logic dirty);
		if (!hit)
			return exc_pkg::EXC_TLB_REFILL;
		if (!ok)
			return exc_pkg::EXC_TLB_INVALID;
		return dirty ? exc_pkg::EXC_NONE : exc_pkg::EXC_TLB_MODIFY;
	endfunction
	task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
		int n;
		n = 0;
		@(posedge clock);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		do begin
			@(posedge clock);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50)
			err_count++;
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	// Slot contents change only while load is low, so blocking writes cannot race the model
	task automatic slot(input int i, input logic [63:0] p);
		next_report[i] = '0;
		next_report[i].valid = 1'b1;
		next_report[i].pc = p;
	endtask
	task automatic issue;
		@(posedge clock);
		load <= 1'b1;
		@(posedge clock);
		load <= 1'b0;
	endtask
	task automatic none;
		int seen;
		seen = 0;
		repeat (6) begin
			@(posedge clock);
			if (redirect === 1'b1)
				seen++;
		end
		chk("no_take", seen, 0);
	endtask
	task automatic take(input logic [3:0] code, input logic [2:0] fl, input logic [31:0] rs);
		int n;
		n = 0;
		while (redirect !== 1'b1 && n < 20) begin
			@(posedge clock);
			n++;
		end
		chk("redirect", redirect, 1);
		chk("redirect_pc", redirect_pc, `HANDLER_ADDR_DEFAULT);
		chk("flush", flush, fl);
		chk("exc_code", exc_code, code);
		chk("kernel", kernel_mode, 1);
		if (code == exc_pkg::EXC_PARITY)
			chk("wb_allow", wb_allow, 1);
		else if (fl == 3'b111 && code != exc_pkg::EXC_INTERRUPT)
			chk("wb_allow_blk", wb_allow, 0);
		next_report = '0;
		issue();
		irq_pending <= 8'hFF;
		none();
		irq_pending <= 8'h00;
		chk("irq_o_set", irq_o, 1);
		wb(1, `OFS_EVENTS, 32'h7);
		wb(0, `OFS_RESTART, 0);
		chk("restart", q, rs);
		chk("irq_o_clr", irq_o, 0);
		return_from_handler <= 1'b1;
		@(posedge clock);
		return_from_handler <= 1'b0;
		repeat (3) @(posedge clock);
		chk("kernel_back", kernel_mode, 0);
	endtask
	initial begin
		rst = 1'b1;
		load = 1'b1;
		next_report = '0;
		irq_pending = 8'h00;
		return_from_handler = 1'b0;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
		void'($urandom(73349));
		repeat (5) @(posedge clock);
		rst <= 1'b0;
		load <= 1'b0;
		wb(0, `OFS_STATUS, 0);
		chk("status_rst", q, `STATUS_RESET);
		chk("kernel_rst", kernel_mode, 1);
		wb(1, `OFS_STATUS, 32'h14);
		wb(1, `OFS_STATUS, 32'h0, 4'h1);
		wb(0, `OFS_STATUS, 0);
		chk("status", q, 32'h14);
		chk("kernel_erl", kernel_mode, 1);
		wb(1, `OFS_STATUS, 32'hFF11);
		wb(0, 6'h20, 0);
		chk("unmapped", q, 0);
		chk("kernel_user", kernel_mode, 0);
		wb(1, `OFS_EVMASK, 32'h1);
		pc = rnd();
		slot(0, pc - 8);
		slot(1, pc);
		slot(2, pc + 4);
		next_report[1].overflow = 1'b1;
		next_report[2].syscall = 1'b1;
		issue();
		take(exc_pkg::EXC_OVERFLOW, 3'b110, pc[31:0]);
		pc = rnd();
		slot(0, pc - 4);
		issue();
		@(posedge clock);
		slot(0, pc);
		next_report[0].in_delay_slot = 1'b1;
		next_report[0].syscall = 1'b1;
		issue();
		take(exc_pkg::EXC_SYSCALL, 3'b111, pc[31:0] - 32'h4);
		for (int k = 0; k < 4; k++) begin
			pc = rnd();
			slot(0, pc);
			next_report[0].tlb_access = 1'b1;
			next_report[0].tlb_store = 1'b1;
			next_report[0].tlb_hit = k > 0;
			next_report[0].tlb_entry_valid = k != 1;
			next_report[0].tlb_entry_dirty = k > 2;
			issue();
			if (k < 3)
				take(tlb_exp(k > 0, k != 1, k > 2), 3'b111, pc[31:0]);
			else
				none();
		end
		pc = rnd();
		slot(0, pc);
		next_report[0].vaddr = pc;
		next_report[0].parity_load_hit = 1'b1;
		issue();
		take(exc_pkg::EXC_PARITY, 3'b111, pc[31:0]);
		wb(0, `OFS_FAULT_INFO, 0);
		chk("fault_info", q, pc[31:0]);
		b = $urandom_range(7);
		wb(1, `OFS_STATUS, 32'h11 | (32'h100 << b));
		pc = rnd();
		slot(0, pc);
		issue();
		irq_pending <= 8'(1 << ((b + 1) % 8));
		none();
		irq_pending <= 8'(1 << b);
		take(exc_pkg::EXC_INTERRUPT, 3'b111, pc[31:0]);
		end_sim();
	end
	initial begin
		repeat (5000) @(posedge clock);
		err_count++;
		end_sim();
	end
endmodule
`default_nettype wire
